/* inc/amr_pkg.sv */
// Package: register map, field layout and codes of the converter result control block
package amr_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] OFF_SELECT = 8'h00; // Input select register
  localparam logic [7:0] OFF_RES_LO = 8'h04; // Result low byte
  localparam logic [7:0] OFF_RES_HI = 8'h08; // Result high byte
  localparam logic [7:0] OFF_STATUS = 8'h0C; // Sticky event status, write one to clear
  localparam logic [7:0] OFF_MASK = 8'h10; // Interrupt mask
  localparam logic [7:0] OFF_ROUTE = 8'h14; // Active routing, read only
  // Reset values
  localparam logic [7:0] SELECT_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  // Field positions of the select register
  localparam int REF_MSB = 7;
  localparam int REF_LSB = 6;
  localparam int ALIGN_BIT = 5;
  localparam int CHAN_MSB = 4;
  // Status bit positions
  localparam int ST_DONE = 0; // Conversion done flag
  localparam int ST_LOST = 1; // Result dropped while pair locked
  // Reference sources
  typedef enum logic [1:0] {
    AMR_REF_EXT = 2'b00,
    AMR_REF_SUPPLY = 2'b01,
    AMR_REF_RSVD = 2'b10,
    AMR_REF_INT = 2'b11
  } amr_ref_t;
  // Gain codes on the route output
  typedef enum logic [1:0] {
    AMR_GAIN_1 = 2'b00,
    AMR_GAIN_10 = 2'b01,
    AMR_GAIN_200 = 2'b10
  } amr_gain_t;
  // Mux codes for the special single-ended sources
  localparam logic [3:0] SRC_BANDGAP = 4'h8;
  localparam logic [3:0] SRC_GROUND = 4'h9;
  // Extreme codes of the two result formats
  localparam logic [9:0] SE_MAX = 10'h3FF;
  localparam logic [9:0] DIFF_MAX = 10'h1FF;
  localparam logic [9:0] DIFF_MIN = 10'h200;
endpackage : amr_pkg

/* src/amr_ctrl.sv */
// Converter input-select, routing and result formatting with APB registers
//
// Contract
// - Single-ended result is unsigned ten-bit code
// - Differential result is ten-bit two's complement
// - Top result bit gives differential polarity
// - Done flag rises with result bytes loaded
// - Select register eight bits, zero after reset
// - Reference field picks external, supply, internal
// - Reference and channel change at completion or while idle
// - Align bit re-presents result bytes immediately
// - Codes 0-7 route single-ended inputs 0-7
// - Codes 8-15 route gain pairs on 0,2
// - Codes 16-31 unity pairs, bandgap, ground
// - Codes 8 and 10 short input 0
// - Right or left byte placement of result
// - Low byte read locks result until high
module amr_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_busy, // Converter core is mid-conversion
  input wire logic conv_done, // One-cycle pulse, raw result valid
  input wire logic [9:0] conv_raw, // Raw code from the core
  output logic [1:0] ref_sel, // Active reference source
  output logic [3:0] pos_sel, // Positive input / source
  output logic [2:0] neg_sel, // Negative input
  output logic diff_mode, // Active selection is differential
  output logic [1:0] gain_sel, // Active gain code
  output logic irq // Level interrupt
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] select_r; // Stored select, software view
  logic [6:0] active_r; // Reference and channel in use
  logic [9:0] result_r; // Latched result
  logic lock_r; // Low byte read, high pending
  logic [1:0] status_r; // Sticky events
  logic [1:0] mask_r; // Interrupt mask
  logic diff_r; // Result came from differential selection

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_sel = paddr == amr_pkg::OFF_SELECT;
  wire hit_lo = paddr == amr_pkg::OFF_RES_LO;
  wire hit_hi = paddr == amr_pkg::OFF_RES_HI;
  wire hit_st = paddr == amr_pkg::OFF_STATUS;
  wire hit_msk = paddr == amr_pkg::OFF_MASK;
  wire hit_rt = paddr == amr_pkg::OFF_ROUTE;
  wire mapped = hit_sel | hit_lo | hit_hi | hit_st | hit_msk | hit_rt;

  //////////////////////////////////////////////////////////////////////////////
  // Routing decode of a five-bit channel code
  function automatic logic [10:0] route(input logic [4:0] c);
    // {diff, gain[1:0], pos[3:0], neg[2:0], spare}
    logic [10:0] r;
    r = 11'h000;
    unique case (c[4:3])
      2'b00: r = {1'b0, amr_pkg::AMR_GAIN_1, 1'b0, c[2:0], 3'h0, 1'b0};
      2'b01: begin
        // Pairs against input 0 or 2; codes 8 and 10 short input 0
        r[10] = 1'b1;
        r[9:8] = c[1] ? amr_pkg::AMR_GAIN_200 : amr_pkg::AMR_GAIN_10;
        // Positive input counts from 0 or from 2, never from 4
        r[7:4] = {2'b00, c[2], c[0]};
        r[3:1] = {1'b0, c[2], 1'b0};
      end
      2'b10: r = {1'b1, amr_pkg::AMR_GAIN_1, 1'b0, c[2:0], 3'h1, 1'b0};
      2'b11: begin
        if (c[2:1] == 2'b11) begin
          // Bandgap or ground, single-ended
          r[7:4] = c[0] ? amr_pkg::SRC_GROUND : amr_pkg::SRC_BANDGAP;
        end else begin
          r = {1'b1, amr_pkg::AMR_GAIN_1, 1'b0, c[2:0], 3'h2, 1'b0};
        end
      end
    endcase
    return r;
  endfunction : route

  wire [10:0] act_route = route(active_r[4:0]);

  //////////////////////////////////////////////////////////////////////////////
  // Result presentation, steered by the live align bit
  wire align_left = select_r[amr_pkg::ALIGN_BIT];
  wire [7:0] res_lo = align_left ? {result_r[1:0], 6'h00} : result_r[7:0];
  wire [7:0] res_hi = align_left ? result_r[9:2] : {6'h00, result_r[9:8]};
  // Completion loads the result unless a pair read is open
  wire load_res = conv_done && !lock_r;
  // A write to the select register mid-conversion, outside the completion cycle, only changes the stored copy
  wire take_active = conv_done || !conv_busy;

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_sel) rd_mux[7:0] = select_r;
    if (hit_lo) rd_mux[7:0] = res_lo;
    if (hit_hi) rd_mux[7:0] = res_hi;
    if (hit_st) rd_mux[1:0] = status_r;
    if (hit_msk) rd_mux[1:0] = mask_r;
    if (hit_rt) rd_mux[10:0] = act_route;
    // Format of the latched result, so software knows whether it is signed
    if (hit_rt) rd_mux[11] = diff_r;
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB answer: zero wait, one cycle ready in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : prdata;
    end
  end
  // Decode of the access phase uses pready so each access acts once
  wire wr_go = wr && pready && mapped;
  wire rd_go = rd && pready;

  //////////////////////////////////////////////////////////////////////////////
  // Select register, stored at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) select_r <= amr_pkg::SELECT_RST;
    else if (wr_go && hit_sel) select_r <= pwdata[7:0];
  end

  // Active copy loaded at completion or while idle
  wire [6:0] sel_pend = (wr_go && hit_sel) ? {pwdata[7:6], pwdata[4:0]}
                                           : {select_r[7:6], select_r[4:0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) active_r <= 7'h00;
    else if (take_active) active_r <= sel_pend;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result latch; raw code is already in the right format for the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= 10'h000;
      diff_r <= 1'b0;
    end else if (load_res) begin
      result_r <= conv_raw;
      diff_r <= act_route[10];
    end
  end

  // Pair lock: set on low read, released on high read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lock_r <= 1'b0;
    else if (rd_go && hit_hi) lock_r <= 1'b0;
    else if (rd_go && hit_lo) lock_r <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status, set wins over write-one clear
  wire [1:0] st_set = {conv_done && lock_r, load_res};
  wire [1:0] st_clr = (wr_go && hit_st) ? pwdata[1:0] : 2'b00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_r <= 2'b00;
    else status_r <= (status_r & ~st_clr) | st_set;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_r <= amr_pkg::MASK_RST;
    else if (wr_go && hit_msk) mask_r <= pwdata[1:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs to the analog front end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sel <= 2'b00;
      pos_sel <= 4'h0;
      neg_sel <= 3'h0;
      diff_mode <= 1'b0;
      gain_sel <= 2'b00;
      irq <= 1'b0;
    end else begin
      ref_sel <= active_r[6:5];
      pos_sel <= act_route[7:4];
      neg_sel <= act_route[3:1];
      diff_mode <= act_route[10];
      gain_sel <= act_route[9:8];
      irq <= |(status_r & mask_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_done_load;
    @(posedge pclk) disable iff (!presetn)
      (conv_done && !lock_r) |=> (result_r == $past(conv_raw)) && status_r[amr_pkg::ST_DONE];
  endproperty
  a_done_load: assert property (p_done_load) else $error("result not loaded at done");

  property p_lock_hold;
    @(posedge pclk) disable iff (!presetn)
      lock_r |=> (result_r == $past(result_r));
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("result changed while locked");

  property p_busy_hold;
    @(posedge pclk) disable iff (!presetn)
      (conv_busy && !conv_done) |=> $stable(active_r);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("selection changed mid-conversion");

  property p_reset_sel;
    @(posedge pclk) $rose(presetn) |-> select_r == amr_pkg::SELECT_RST;
  endproperty
  a_reset_sel: assert property (p_reset_sel) else $error("select not zero after reset");

  property p_left;
    @(posedge pclk) disable iff (!presetn)
      align_left |-> res_hi == result_r[9:2] && res_lo == {result_r[1:0], 6'h00};
  endproperty
  a_left: assert property (p_left) else $error("left alignment wrong");

  property p_right;
    @(posedge pclk) disable iff (!presetn)
      !align_left |-> res_hi[7:2] == 6'h00 && {res_hi[1:0], res_lo} == result_r;
  endproperty
  a_right: assert property (p_right) else $error("right alignment wrong");

  property p_ref_out;
    @(posedge pclk) disable iff (!presetn) ##1 ref_sel == $past(active_r[6:5]);
  endproperty
  a_ref_out: assert property (p_ref_out) else $error("reference output wrong");

  property p_short;
    @(posedge pclk) disable iff (!presetn)
      (active_r[4:0] == 5'h08 || active_r[4:0] == 5'h0A) |=> diff_mode && pos_sel == 4'h0
        && neg_sel == 3'h0;
  endproperty
  a_short: assert property (p_short) else $error("offset calibration pair wrong");

  property p_single;
    @(posedge pclk) disable iff (!presetn)
      (active_r[4:3] == 2'b00) |=> !diff_mode && pos_sel == {1'b0, $past(active_r[2:0])};
  endproperty
  a_single: assert property (p_single) else $error("single-ended route wrong");

  property p_irq;
    @(posedge pclk) disable iff (!presetn) ##1 irq == $past(|(status_r & mask_r));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_lock_set;
    @(posedge pclk) disable iff (!presetn)
      (rd_go && hit_lo) |=> lock_r;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("low read did not lock");

  property p_lost;
    @(posedge pclk) disable iff (!presetn)
      (conv_done && lock_r) |=> status_r[amr_pkg::ST_LOST] && $stable(result_r);
  endproperty
  a_lost: assert property (p_lost) else $error("locked result overwritten");

  property p_gain_pair;
    @(posedge pclk) disable iff (!presetn)
      (active_r[4:3] == 2'b01) |=> diff_mode
        && pos_sel == {2'b00, $past(active_r[2]), $past(active_r[0])}
        && neg_sel == {1'b0, $past(active_r[2]), 1'b0}
        && gain_sel == ($past(active_r[1]) ? amr_pkg::AMR_GAIN_200 : amr_pkg::AMR_GAIN_10);
  endproperty
  a_gain_pair: assert property (p_gain_pair) else $error("gain pair route wrong");

  property p_unity;
    @(posedge pclk) disable iff (!presetn)
      (active_r[4:3] == 2'b10) |=> diff_mode && gain_sel == amr_pkg::AMR_GAIN_1
        && neg_sel == 3'h1 && pos_sel == {1'b0, $past(active_r[2:0])};
  endproperty
  a_unity: assert property (p_unity) else $error("unity pair route wrong");

  property p_special;
    @(posedge pclk) disable iff (!presetn)
      (active_r[4:1] == 4'hF) |=> !diff_mode
        && pos_sel == ($past(active_r[0]) ? amr_pkg::SRC_GROUND : amr_pkg::SRC_BANDGAP);
  endproperty
  a_special: assert property (p_special) else $error("bandgap or ground route wrong");

  property p_sel_store;
    @(posedge pclk) disable iff (!presetn)
      (wr_go && hit_sel) |=> select_r == $past(pwdata[7:0]);
  endproperty
  a_sel_store: assert property (p_sel_store) else $error("select write not stored");

  property p_take_idle;
    @(posedge pclk) disable iff (!presetn)
      (!conv_busy || conv_done) |=> active_r == $past(sel_pend);
  endproperty
  a_take_idle: assert property (p_take_idle) else $error("active copy not loaded");

endmodule : amr_ctrl

/* test/amr_ctrl_tb.sv */
// Testbench: register-level checks of the converter result control block
module amr_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////////
  logic pclk = 1'b0; // System clock, 10 MHz
  logic presetn = 1'b0; // Reset, active low
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_busy = 1'b0; // Core converting
  logic conv_done = 1'b0; // Core result strobe
  logic [9:0] conv_raw = 10'h000; // Core result code
  logic [1:0] ref_sel;
  logic [3:0] pos_sel;
  logic [2:0] neg_sel;
  logic diff_mode;
  logic [1:0] gain_sel;
  logic irq;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0; // Hang guard
  logic [31:0] rd; // Last read data
  logic err; // Last slave error
  // Extreme codes of both formats
  logic [9:0] res_tab [4] = '{amr_pkg::DIFF_MIN, amr_pkg::DIFF_MAX, amr_pkg::SE_MAX, 10'h000};
  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  always #50 pclk = ~pclk;
  amr_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_busy(conv_busy), .conv_done(conv_done), .conv_raw(conv_raw),
    .ref_sel(ref_sel), .pos_sel(pos_sel), .neg_sel(neg_sel), .diff_mode(diff_mode),
    .gain_sel(gain_sel), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  // Closing report, single exit point
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for pready, never assumes its latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the hang guard ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Read and compare
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rchk
  // Core completion pulse, then let routing settle
  task automatic done_pulse(input logic [9:0] v);
    @(posedge pclk);
    conv_raw <= v;
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : done_pulse
  // Expected routing {diff, gain, pos, neg}; neg only meaningful when differential
  function automatic logic [9:0] route_exp(input logic [4:0] c);
    logic [9:0] r;
    if (c < 5'h08) r = {1'b0, 2'h0, 1'b0, c[2:0], 3'h0};
    else if (c < 5'h10) r = {1'b1, c[1] ? 2'h2 : 2'h1, 2'h0, c[2], c[0], 1'b0, c[2], 1'b0};
    else if (c < 5'h18) r = {1'b1, 2'h0, 1'b0, c[2:0], 3'h1};
    else if (c < 5'h1E) r = {1'b1, 2'h0, 1'b0, c[2:0], 3'h2};
    else r = {1'b0, 2'h0, c[0] ? amr_pkg::SRC_GROUND : amr_pkg::SRC_BANDGAP, 3'h0};
    return r;
  endfunction : route_exp
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard; whole run is well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk(amr_pkg::OFF_SELECT, 32'h0000_0000);
    rchk(amr_pkg::OFF_MASK, 32'h0000_0000);
    // Every channel code, reference codes cycled alongside
    for (int c = 0; c < 32; c++) begin
      logic [4:0] k;
      k = 5'(c);
      apb(1'b1, amr_pkg::OFF_SELECT, {24'h0, k[1:0], 1'b0, k});
      rchk(amr_pkg::OFF_SELECT, {24'h0, k[1:0], 1'b0, k});
      repeat (3) @(posedge pclk);
      chk({30'h0, ref_sel}, {30'h0, k[1:0]});
      chk({22'h0, diff_mode, gain_sel, pos_sel, diff_mode ? neg_sel : 3'h0}, {22'h0, route_exp(k)});
    end
    // Selection change mid-conversion waits for completion
    conv_busy <= 1'b1;
    apb(1'b1, amr_pkg::OFF_SELECT, 32'h0000_0045);
    repeat (3) @(posedge pclk);
    chk({26'h0, ref_sel, pos_sel}, {26'h0, 2'h3, amr_pkg::SRC_GROUND});
    rchk(amr_pkg::OFF_SELECT, 32'h0000_0045);
    done_pulse(10'h270);
    chk({26'h0, ref_sel, pos_sel}, {26'h0, 2'h1, 4'h5});
    rchk(amr_pkg::OFF_ROUTE, 32'h0000_0050);
    conv_busy <= 1'b0;
    // Completion flag and interrupt
    rchk(amr_pkg::OFF_STATUS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, amr_pkg::OFF_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    rchk(amr_pkg::OFF_RES_LO, 32'h0000_0070);
    rchk(amr_pkg::OFF_RES_HI, 32'h0000_0002);
    apb(1'b1, amr_pkg::OFF_SELECT, 32'h0000_0065);
    rchk(amr_pkg::OFF_RES_LO, 32'h0000_0000);
    rchk(amr_pkg::OFF_RES_HI, 32'h0000_009C);
    apb(1'b1, amr_pkg::OFF_STATUS, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    // Completion between low and high read is dropped
    rchk(amr_pkg::OFF_RES_LO, 32'h0000_0000);
    done_pulse(10'h155);
    rchk(amr_pkg::OFF_RES_HI, 32'h0000_009C);
    apb(1'b0, amr_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0002, 32'h0000_0002);
    rchk(amr_pkg::OFF_RES_LO, 32'h0000_0000);
    rchk(amr_pkg::OFF_RES_HI, 32'h0000_009C);
    // Sign in the top bit, left aligned
    apb(1'b1, amr_pkg::OFF_SELECT, 32'h0000_00ED);
    done_pulse(amr_pkg::DIFF_MIN);
    rchk(amr_pkg::OFF_RES_LO, 32'h0000_0000);
    rchk(amr_pkg::OFF_RES_HI, 32'h0000_0080);
    rchk(amr_pkg::OFF_ROUTE, 32'h0000_0D34);
    apb(1'b1, amr_pkg::OFF_SELECT, 32'h0000_0045);
    // Extreme codes, right aligned
    for (int i = 0; i < 4; i++) begin
      logic [9:0] v;
      v = res_tab[i];
      done_pulse(v);
      rchk(amr_pkg::OFF_RES_LO, {24'h0, v[7:0]});
      rchk(amr_pkg::OFF_RES_HI, {30'h0, v[9:8]});
    end
    // Unmapped address refused, write ignored
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 8'h18, 32'h0000_00FF);
    rchk(amr_pkg::OFF_SELECT, 32'h0000_0045);
    give_verdict();
  end
endmodule : amr_ctrl_tb
